// ---- common/ust_pkg.sv ----
// Shared constants, types and helper functions of the serial transceiver.
package ust_pkg;

	// ------------------------------------------------------------
	// Frame format constants
	// ------------------------------------------------------------
	localparam logic [2:0] CSZ_NINE   = 3'h7;
	localparam logic [3:0] NB_MIN     = 4'h5;
	localparam logic [3:0] NB_NINE    = 4'h9;
	localparam logic [8:0] MASK_ALL   = 9'h1ff;
	localparam logic       LINE_IDLE  = 1'b1;
	localparam logic       LINE_START = 1'b0;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;
	localparam logic [3:0] CNT_ONE    = 4'h1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       ovr;
		logic       fe;
		logic       pe;
		logic [8:0] dat;
	} ust_entry_t;

	typedef struct packed {
		logic [8:0] dat;
		logic [3:0] nb;
		logic       pen;
		logic       par;
		logic       two;
	} ust_txw_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ust_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} ust_rx_st_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] ust_nbits(input logic [2:0] code);
		ust_nbits = (code == CSZ_NINE) ? NB_NINE : NB_MIN + {2'h0, code[1:0]};
	endfunction

	function automatic logic [8:0] ust_mask(input logic [3:0] nb);
		ust_mask = MASK_ALL >> (NB_NINE - nb);
	endfunction

endpackage

// ---- common/ust_fifo_if.sv ----
// Port bundle between the transceiver and its receive buffer memory.
`timescale 1ns/1ps
interface ust_fifo_if;
	import ust_pkg::*;
	logic       we;
	logic       waddr;
	logic       raddr;
	ust_entry_t wdata;
	ust_entry_t rdata;
	modport ctl (output we, output waddr, output raddr, output wdata, input rdata);
	modport mem (input we, input waddr, input raddr, input wdata, output rdata);
endinterface

// ---- hdl/ust_rx_mem.sv ----
// Two-entry receive buffer memory with registered read data.
`timescale 1ns/1ps
module ust_rx_mem
	import ust_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic nrst,
	ust_fifo_if.mem   f
);

	ust_entry_t mem_r [2];

	always_ff @(posedge core_clk) begin
		if (f.we) begin
			mem_r[f.waddr] <= f.wdata;
		end
	end

	// Write-through keeps the head valid when a frame lands in the slot being read.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			f.rdata <= '0;
		end else if (f.we && f.waddr == f.raddr) begin
			f.rdata <= f.wdata;
		end else begin
			f.rdata <= mem_r[f.raddr];
		end
	end

endmodule

// ---- hdl/ust_usart.sv ----
// Serial transceiver transmit and receive data paths with buffers and flags.
`timescale 1ns/1ps
// Summary of operation
// - Empty flag is one while the transmit buffer is empty, else zero.
// - Writing the data register while transmit enable is set clears the empty flag.
// - Empty interrupt stays asserted while enabled and the empty flag is set.
// - Transmit complete sets when the frame is out and nothing is buffered.
// - Transmit complete clears on interrupt service or on a written one.
// - Transmit complete interrupt rises with the flag when enabled.
// - With parity enabled a parity bit follows the last data bit.
// - Clearing transmit enable waits until shift register and buffer are empty.
// - Once really disabled the transmit pin returns to port function.
// - Receive enable makes the receive pin the serial input.
// - The receiver uses the external serial clock as bit clock.
// - Reception starts on a start bit; bits shift in up to first stop.
// - A second stop bit is ignored by the receiver.
// - On the first stop bit the frame moves into the receive buffer.
// - Unused upper data bits read as zero for short characters.
// - Ninth bit and error flags are stored per entry and advance on read.
// - Reading the data register frees that buffer entry at once.
// - Receive complete shows unread data and clears on receiver disable.
// - The receive buffer holds two characters beside the shift register.
// - The shift register loads when idle or right after the last stop bit.
// - Frame order is start, data lsb first, parity, stop bits.
module ust_usart
	import ust_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       serial_clock_pin,
	input  wire logic       rxd_pin,
	input  wire logic       data_wr,
	input  wire logic [7:0] data_wdata,
	input  wire logic       tx_ninth_bit,
	input  wire logic       data_rd,
	input  wire logic       tx_complete_clr,
	input  wire logic       tx_complete_irq_ack,
	input  wire logic       empty_irq_enable,
	input  wire logic       tx_complete_irq_enable,
	input  wire logic       tx_enable_bit,
	input  wire logic       rx_enable_bit,
	input  wire logic [2:0] char_size_code,
	input  wire logic       parity_enable_bit,
	input  wire logic       parity_odd_bit,
	input  wire logic       two_stop_bit,
	output logic            data_reg_empty,
	output logic            tx_complete,
	output logic            empty_irq,
	output logic            tx_complete_irq,
	output logic            txd_out,
	output logic            txd_oe,
	output logic            rxd_override,
	output logic            rx_complete,
	output logic [7:0]      rx_data,
	output logic            rx_ninth_bit,
	output logic            frame_error,
	output logic            overrun_error,
	output logic            parity_error
);

	// ------------------------------------------------------------
	// Core side transmit buffer
	// ------------------------------------------------------------
	ust_txw_t   txw_r;
	logic       tx_req_r, ack_s1, ack_s2, ack_s3, done_s1, done_s2, done_s3;
	logic       tx_ack_r, tx_done_r;
	logic       empty_r, busy_r, txc_r, empty_irq_r, txc_irq_r, oe_r;
	logic       wr_ok, ack_evt, done_evt, empty_nxt, busy_nxt, txc_nxt;
	logic [8:0] wr_dat;
	logic [3:0] wr_nb;

	assign wr_ok     = data_wr && tx_enable_bit && empty_r;
	assign ack_evt   = ack_s2 ^ ack_s3;
	assign done_evt  = done_s2 ^ done_s3;
	assign wr_nb     = ust_nbits(char_size_code);
	assign wr_dat    = {tx_ninth_bit, data_wdata} & ust_mask(wr_nb);
	// Only the second and third stages are read, so a metastable first stage never reaches logic.
	assign empty_nxt = (tx_req_r ^ wr_ok) == ack_s2;
	assign busy_nxt  = ack_evt ? 1'b1 : (done_evt ? 1'b0 : busy_r);
	assign txc_nxt   = (done_evt && !ack_evt && empty_r) ? 1'b1 :
	                   ((tx_complete_clr || tx_complete_irq_ack) ? 1'b0 : txc_r);

	// The whole character and its format travel as one word; the link side reads it
	// only while the request toggle is pending, so it never changes under the reader.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			txw_r    <= '0;
			tx_req_r <= 1'b0;
		end else if (wr_ok) begin
			txw_r    <= '{wr_dat, wr_nb, parity_enable_bit, (^wr_dat) ^ parity_odd_bit,
			              two_stop_bit};
			tx_req_r <= ~tx_req_r;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			{ack_s1, ack_s2, ack_s3}    <= '0;
			{done_s1, done_s2, done_s3} <= '0;
		end else begin
			{ack_s1, ack_s2, ack_s3}    <= {tx_ack_r, ack_s1, ack_s2};
			{done_s1, done_s2, done_s3} <= {tx_done_r, done_s1, done_s2};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			empty_r     <= 1'b1;
			busy_r      <= 1'b0;
			txc_r       <= 1'b0;
			empty_irq_r <= 1'b0;
			txc_irq_r   <= 1'b0;
			oe_r        <= 1'b0;
		end else begin
			empty_r     <= empty_nxt;
			busy_r      <= busy_nxt;
			txc_r       <= txc_nxt;
			empty_irq_r <= empty_irq_enable && empty_nxt;
			txc_irq_r   <= tx_complete_irq_enable && txc_nxt;
			oe_r        <= tx_enable_bit || !empty_nxt || busy_nxt;
		end
	end

	// ------------------------------------------------------------
	// Link side transmitter
	// ------------------------------------------------------------
	ust_tx_st_t tst_r;
	ust_txw_t   tw_r;
	logic       treq_s1, treq_s2, tsec_r, txd_r;
	logic [3:0] tcnt_r;
	logic       pend, stop_last, load;

	assign pend      = treq_s2 != tx_ack_r;
	assign stop_last = (tst_r == TX_STOP) && (!tw_r.two || tsec_r);
	assign load      = pend && (tst_r == TX_IDLE || stop_last);

	always_ff @(posedge serial_clock_pin or negedge nrst) begin
		if (!nrst) begin
			{treq_s1, treq_s2} <= '0;
			tx_done_r          <= 1'b0;
		end else begin
			{treq_s1, treq_s2} <= {tx_req_r, treq_s1};
			if (stop_last) begin
				tx_done_r <= ~tx_done_r;
			end
		end
	end

	always_ff @(posedge serial_clock_pin or negedge nrst) begin
		if (!nrst) begin
			tst_r    <= TX_IDLE;
			tw_r     <= '0;
			tx_ack_r <= 1'b0;
			tsec_r   <= 1'b0;
			tcnt_r   <= '0;
			txd_r    <= LINE_IDLE;
		end else if (load) begin
			tw_r     <= txw_r;
			tx_ack_r <= ~tx_ack_r;
			txd_r    <= LINE_START;
			tst_r    <= TX_START;
		end else begin
			case (tst_r)
				TX_START: begin
					txd_r     <= tw_r.dat[0];
					tw_r.dat  <= tw_r.dat >> 1;
					tcnt_r    <= CNT_ONE;
					tst_r     <= TX_DATA;
				end
				TX_DATA: begin
					tsec_r <= 1'b0;
					if (tcnt_r == tw_r.nb) begin
						txd_r <= tw_r.pen ? tw_r.par : LINE_IDLE;
						tst_r <= tw_r.pen ? TX_PAR : TX_STOP;
					end else begin
						txd_r    <= tw_r.dat[0];
						tw_r.dat <= tw_r.dat >> 1;
						tcnt_r   <= tcnt_r + CNT_ONE;
					end
				end
				TX_PAR: begin
					txd_r <= LINE_IDLE;
					tst_r <= TX_STOP;
				end
				TX_STOP: begin
					tsec_r <= 1'b1;
					if (stop_last) begin
						tst_r <= TX_IDLE;
					end
				end
				default: begin
					txd_r <= LINE_IDLE;
					tst_r <= TX_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Link side receiver
	// ------------------------------------------------------------
	ust_rx_st_t rst_r;
	ust_entry_t rx_hold_r;
	logic [5:0] cfg_s1, cfg_s2;
	logic       rxd_s1, rxd_s2, rpb_r, rx_tog_r;
	logic [8:0] rsh_r;
	logic [3:0] rcnt_r, rnb;

	assign rnb = ust_nbits(cfg_s2[2:0]);

	// Format bits are quasi-static; changing them mid-frame corrupts that frame anyway.
	always_ff @(posedge serial_clock_pin or negedge nrst) begin
		if (!nrst) begin
			{cfg_s1, cfg_s2} <= '0;
			{rxd_s1, rxd_s2} <= {LINE_IDLE, LINE_IDLE};
		end else begin
			cfg_s1           <= {rx_enable_bit, parity_enable_bit, parity_odd_bit,
			                     char_size_code};
			cfg_s2           <= cfg_s1;
			{rxd_s1, rxd_s2} <= {rxd_pin, rxd_s1};
		end
	end

	always_ff @(posedge serial_clock_pin or negedge nrst) begin
		if (!nrst) begin
			rst_r     <= RX_IDLE;
			rsh_r     <= '0;
			rcnt_r    <= '0;
			rpb_r     <= 1'b0;
			rx_hold_r <= '0;
			rx_tog_r  <= 1'b0;
		end else if (!cfg_s2[5]) begin
			rst_r <= RX_IDLE;
		end else begin
			case (rst_r)
				RX_IDLE: begin
					if (rxd_s2 == LINE_START) begin
						rst_r  <= RX_DATA;
						rsh_r  <= '0;
						rcnt_r <= '0;
					end
				end
				RX_DATA: begin
					rsh_r[rcnt_r] <= rxd_s2;
					rcnt_r        <= rcnt_r + CNT_ONE;
					if (rcnt_r + CNT_ONE == rnb) begin
						rst_r <= cfg_s2[4] ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: begin
					rpb_r <= rxd_s2;
					rst_r <= RX_STOP;
				end
				RX_STOP: begin
					rx_hold_r <= '{1'b0, !rxd_s2,
					               cfg_s2[4] && ((^rsh_r) ^ cfg_s2[3] ^ rpb_r), rsh_r};
					rx_tog_r  <= ~rx_tog_r;
					rst_r     <= RX_IDLE;
				end
				default: begin
					rst_r <= RX_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Core side receive buffer
	// ------------------------------------------------------------
	ust_fifo_if f ();
	logic       rtog_s1, rtog_s2, rtog_s3, rx_evt, pop, room, push, lost;
	logic       wp_r, rp_r, ovr_pend_r, rxc_r, rxo_r;
	logic [1:0] cnt_r, cnt_nxt;

	// The hold register stays put for a whole frame after its toggle, far longer
	// than the three core cycles needed to see the toggle and copy it.
	assign rx_evt  = rtog_s2 ^ rtog_s3;
	assign pop     = data_rd && cnt_r != 2'h0;
	assign room    = cnt_r != FIFO_DEPTH || pop;
	assign push    = rx_evt && rx_enable_bit && room;
	assign lost    = rx_evt && rx_enable_bit && !room;
	assign cnt_nxt = !rx_enable_bit ? 2'h0 : cnt_r + {1'b0, push} - {1'b0, pop};

	assign f.we    = push;
	assign f.waddr = wp_r;
	assign f.raddr = rp_r ^ pop;
	assign f.wdata = '{ovr_pend_r, rx_hold_r.fe, rx_hold_r.pe, rx_hold_r.dat};

	ust_rx_mem u_mem (
		.core_clk (core_clk),
		.nrst     (nrst),
		.f        (f.mem)
	);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			{rtog_s1, rtog_s2, rtog_s3} <= '0;
		end else begin
			{rtog_s1, rtog_s2, rtog_s3} <= {rx_tog_r, rtog_s1, rtog_s2};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wp_r       <= 1'b0;
			rp_r       <= 1'b0;
			cnt_r      <= '0;
			ovr_pend_r <= 1'b0;
			rxc_r      <= 1'b0;
			rxo_r      <= 1'b0;
		end else begin
			rxo_r <= rx_enable_bit;
			cnt_r <= cnt_nxt;
			rxc_r <= cnt_nxt != 2'h0;
			if (!rx_enable_bit) begin
				wp_r       <= 1'b0;
				rp_r       <= 1'b0;
				ovr_pend_r <= 1'b0;
			end else begin
				wp_r       <= wp_r ^ push;
				rp_r       <= rp_r ^ pop;
				ovr_pend_r <= lost || (ovr_pend_r && !push);
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign data_reg_empty  = empty_r;
	assign tx_complete     = txc_r;
	assign empty_irq       = empty_irq_r;
	assign tx_complete_irq = txc_irq_r;
	assign txd_out         = txd_r;
	assign txd_oe          = oe_r;
	assign rxd_override    = rxo_r;
	assign rx_complete     = rxc_r;
	assign rx_data         = f.rdata.dat[7:0];
	assign rx_ninth_bit    = f.rdata.dat[8];
	assign frame_error     = f.rdata.fe;
	assign overrun_error   = f.rdata.ovr;
	assign parity_error    = f.rdata.pe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_wr_clears;
		@(posedge core_clk) disable iff (!nrst) wr_ok |=> !empty_r ##1 !empty_r;
	endproperty
	a_wr_clears: assert property (p_wr_clears) else $error("write left empty set");

	property p_empty_irq;
		@(posedge core_clk) disable iff (!nrst)
			(empty_irq_enable && empty_r)[*2] |-> empty_irq_r;
	endproperty
	a_empty_irq: assert property (p_empty_irq) else $error("empty irq missing");

	property p_txc_set;
		@(posedge core_clk) disable iff (!nrst)
			done_evt && !ack_evt && empty_r |=> txc_r;
	endproperty
	a_txc_set: assert property (p_txc_set) else $error("tx complete not set");

	property p_txc_clr;
		@(posedge core_clk) disable iff (!nrst)
			(tx_complete_clr || tx_complete_irq_ack) && !done_evt |=> !txc_r;
	endproperty
	a_txc_clr: assert property (p_txc_clr) else $error("tx complete not cleared");

	property p_txc_irq;
		@(posedge core_clk) disable iff (!nrst)
			$rose(txc_r) && $past(tx_complete_irq_enable) |-> txc_irq_r;
	endproperty
	a_txc_irq: assert property (p_txc_irq) else $error("tx complete irq missing");

	property p_oe_hold;
		@(posedge core_clk) disable iff (!nrst) !empty_r || (busy_r && !done_evt) |=> oe_r;
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("pin released early");

	property p_rx_ovr;
		@(posedge core_clk) disable iff (!nrst) rx_enable_bit |=> rxd_override;
	endproperty
	a_rx_ovr: assert property (p_rx_ovr) else $error("rx pin not taken");

	property p_rx_flush;
		@(posedge core_clk) disable iff (!nrst) !rx_enable_bit |=> !rx_complete && cnt_r == 2'h0;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("flush failed");

	property p_rx_push;
		@(posedge core_clk) disable iff (!nrst)
			rx_evt && rx_enable_bit && cnt_r == 2'h0 |=> rx_complete;
	endproperty
	a_rx_push: assert property (p_rx_push) else $error("frame not stored");

	property p_pop_free;
		@(posedge core_clk) disable iff (!nrst)
			pop && cnt_r == FIFO_DEPTH && !rx_evt && rx_enable_bit |=> cnt_r == 2'h1;
	endproperty
	a_pop_free: assert property (p_pop_free) else $error("read did not free");

	property p_tx_start;
		@(posedge serial_clock_pin) disable iff (!nrst)
			load |=> txd_out == LINE_START ##1 tst_r == TX_DATA;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("bad start bit");

	c_back2back: cover property (@(posedge serial_clock_pin) disable iff (!nrst)
		stop_last && load);
	c_txc: cover property (@(posedge core_clk) disable iff (!nrst) $rose(txc_r));
	c_rx_full: cover property (@(posedge core_clk) disable iff (!nrst) cnt_r == FIFO_DEPTH);
	c_overrun: cover property (@(posedge core_clk) disable iff (!nrst) lost);

endmodule

// ---- verification/ust_peer_model.sv ----
// Behavioural model of the remote serial peer that owns the link clock.
`timescale 1ns/1ps
module ust_peer_model (
	output logic            sclk,
	output logic            rxd,
	input  wire logic       txd_out,
	input  wire logic       txd_oe,
	input  wire logic       clk_run,
	input  wire logic [3:0] nb,
	input  wire logic       pen
);
	logic        sending;
	int          cnt;
	logic [11:0] sh;
	logic [11:0] got_q[$];

	// ------------------------------------------------------------
	// Link clock
	// ------------------------------------------------------------
	// The clock stands still unless clk_run is set or a frame is on its way to the receiver.
	initial begin
		sclk    = 1'b0;
		rxd     = 1'b1;
		sending = 1'b0;
		cnt     = 0;
		#7;
		forever begin
			#16;
			sclk = (clk_run || sending) ? ~sclk : 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Sender and capture
	// ------------------------------------------------------------
	// Bits change on the falling edge, so the receiver samples them settled.
	task automatic send(input logic [8:0] d, input int n, input logic p_en, input logic pb,
			input logic s1, input logic s2);
		int i;
		sending = 1'b1;
		@(negedge sclk) rxd = 1'b0;
		for (i = 0; i < n; i++) begin
			@(negedge sclk) rxd = d[i];
		end
		if (p_en) begin
			@(negedge sclk) rxd = pb;
		end
		@(negedge sclk) rxd = s1;
		@(negedge sclk) rxd = s2;
		@(negedge sclk) rxd = 1'b1;
		repeat (4) @(negedge sclk);
		sending = 1'b0;
	endtask

	// Captured frame layout: data from bit 0, then parity, then the first stop bit.
	always @(negedge sclk) begin
		if (cnt == 0) begin
			if (txd_oe === 1'b1 && txd_out === 1'b0) begin
				cnt = 1;
				sh  = '0;
			end
		end else begin
			sh[cnt - 1] = txd_out;
			if (cnt == nb + pen + 1) begin
				got_q.push_back(sh);
				cnt = 0;
			end else begin
				cnt++;
			end
		end
	end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the serial transceiver data paths and flags.
`timescale 1ns/1ps
module tb_top;
	logic       core_clk, nrst, serial_clock_pin, rxd_pin, data_wr, tx_ninth_bit, data_rd;
	logic       tx_complete_clr, tx_complete_irq_ack, empty_irq_enable, tx_complete_irq_enable;
	logic       tx_enable_bit, rx_enable_bit, parity_enable_bit, parity_odd_bit, two_stop_bit;
	logic [2:0] char_size_code;
	logic [7:0] data_wdata, rx_data;
	logic       data_reg_empty, tx_complete, empty_irq, tx_complete_irq, txd_out, txd_oe;
	logic       rxd_override, rx_complete, rx_ninth_bit, frame_error, overrun_error;
	logic       parity_error, clk_run;
	int         n_errors, checked, nbits, i;
	logic [2:0] codes [3] = '{3'h3, 3'h7, 3'h0};
	logic [8:0] d1 [3]    = '{9'h0a5, 9'h1a5, 9'h0f6};
	logic [8:0] d2 [3]    = '{9'h03c, 9'h05a, 9'h1e9};
	logic       pens [3]  = '{1'b0, 1'b1, 1'b1};
	logic       odds [3]  = '{1'b0, 1'b1, 1'b0};

	ust_usart dut (
		.core_clk(core_clk),
		.nrst(nrst),
		.serial_clock_pin(serial_clock_pin),
		.rxd_pin(rxd_pin),
		.data_wr(data_wr),
		.data_wdata(data_wdata),
		.tx_ninth_bit(tx_ninth_bit),
		.data_rd(data_rd),
		.tx_complete_clr(tx_complete_clr),
		.tx_complete_irq_ack(tx_complete_irq_ack),
		.empty_irq_enable(empty_irq_enable),
		.tx_complete_irq_enable(tx_complete_irq_enable),
		.tx_enable_bit(tx_enable_bit),
		.rx_enable_bit(rx_enable_bit),
		.char_size_code(char_size_code),
		.parity_enable_bit(parity_enable_bit),
		.parity_odd_bit(parity_odd_bit),
		.two_stop_bit(two_stop_bit),
		.data_reg_empty(data_reg_empty),
		.tx_complete(tx_complete),
		.empty_irq(empty_irq),
		.tx_complete_irq(tx_complete_irq),
		.txd_out(txd_out),
		.txd_oe(txd_oe),
		.rxd_override(rxd_override),
		.rx_complete(rx_complete),
		.rx_data(rx_data),
		.rx_ninth_bit(rx_ninth_bit),
		.frame_error(frame_error),
		.overrun_error(overrun_error),
		.parity_error(parity_error)
	);

	ust_peer_model peer (
		.sclk(serial_clock_pin),
		.rxd(rxd_pin),
		.txd_out(txd_out),
		.txd_oe(txd_oe),
		.clk_run(clk_run),
		.nb(nbits[3:0]),
		.pen(parity_enable_bit)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [8:0] mask();
		return 9'h1ff >> (9 - nbits);
	endfunction

	function automatic logic [11:0] tx_frame(input logic [8:0] d);
		logic [11:0] f;
		f = {3'h0, d & mask()};
		if (parity_enable_bit) f[nbits] = ^(d & mask()) ^ parity_odd_bit;
		f[nbits + int'(parity_enable_bit)] = 1'b1;
		return f;
	endfunction

	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for data_reg_empty (0), tx_complete (1) or rx_complete (2).
	task automatic wait_hi(input int w);
		for (i = 0; i < 3000; i++) begin
			@(negedge core_clk);
			if ((w == 0 && data_reg_empty === 1'b1) || (w == 1 && tx_complete === 1'b1) ||
					(w == 2 && rx_complete === 1'b1)) break;
		end
		if (i == 3000) chk("wait flag", w, 12'hfff);
	endtask

	task automatic fmt(input logic [2:0] code, input logic pen, input logic odd, input logic two);
		char_size_code    = code;
		parity_enable_bit = pen;
		parity_odd_bit    = odd;
		two_stop_bit      = two;
		nbits             = (code == 3'h7) ? 9 : 5 + code[1:0];
	endtask

	// A late change of the ninth bit must not reach the buffered character.
	task automatic wr(input logic [8:0] d);
		int k;
		k = i;
		wait_hi(0);
		data_wr      = 1'b1;
		data_wdata   = d[7:0];
		tx_ninth_bit = d[8];
		@(negedge core_clk);
		data_wr      = 1'b0;
		tx_ninth_bit = ~d[8];
		repeat (2) @(negedge core_clk);
		chk("data_reg_empty", 1'b0, data_reg_empty);
		chk("empty_irq", 1'b0, empty_irq);
		i = k;
	endtask

	task automatic rsend(input logic [8:0] d, input logic pbad, input logic s1, input logic s2);
		peer.send(d, nbits, parity_enable_bit, ^(d & mask()) ^ parity_odd_bit ^ pbad, s1, s2);
	endtask

	task automatic rd(input logic [8:0] d, input logic fe, input logic ov, input logic pe);
		wait_hi(2);
		chk("rx_ninth_bit", {3'h0, d & mask()} >> 8, rx_ninth_bit);
		chk("rx_data", d[7:0] & mask(), rx_data);
		chk("frame_error", fe, frame_error);
		chk("overrun_error", ov, overrun_error);
		chk("parity_error", pe, parity_error);
		data_rd = 1'b1;
		@(negedge core_clk);
		data_rd = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic summarize();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		n_errors = 0;
		checked  = 0;
		nrst     = 1'b0;
		clk_run  = 1'b1;
		{data_wr, data_rd, tx_complete_clr, tx_complete_irq_ack, tx_ninth_bit} = 5'h0;
		data_wdata = 8'h00;
		{empty_irq_enable, tx_complete_irq_enable, tx_enable_bit, rx_enable_bit} = 4'he;
		fmt(3'h3, 1'b0, 1'b0, 1'b0);
		repeat (12) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		chk("data_reg_empty", 1'b1, data_reg_empty);
		chk("empty_irq", 1'b1, empty_irq);
		for (int j = 0; j < 3; j++) begin
			fmt(codes[j], pens[j], odds[j], j == 1);
			wr(d1[j]);
			chk("tx_complete", 1'b0, tx_complete);
			wr(d2[j]);
			wait_hi(1);
			@(negedge core_clk);
			chk("tx_complete_irq", 1'b1, tx_complete_irq);
			repeat (4) @(negedge core_clk);
			chk("frame first", tx_frame(d1[j]), peer.got_q.pop_front());
			chk("frame second", tx_frame(d2[j]), peer.got_q.pop_front());
			tx_complete_clr     = (j != 1);
			tx_complete_irq_ack = (j == 1);
			@(negedge core_clk);
			{tx_complete_clr, tx_complete_irq_ack} = 2'h0;
			@(negedge core_clk);
			chk("tx_complete", 1'b0, tx_complete);
		end
		fmt(3'h3, 1'b0, 1'b0, 1'b0);
		wr(9'h0c3);
		tx_enable_bit = 1'b0;
		@(negedge core_clk);
		chk("txd_oe", 1'b1, txd_oe);
		wait_hi(1);
		repeat (6) @(negedge core_clk);
		chk("frame pending", tx_frame(9'h0c3), peer.got_q.pop_front());
		chk("txd_oe", 1'b0, txd_oe);
		clk_run = 1'b0;
		fmt(3'h2, 1'b1, 1'b0, 1'b1);
		rx_enable_bit = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("rxd_override", 1'b1, rxd_override);
		rsend(9'h1d5, 1'b0, 1'b1, 1'b1);
		rsend(9'h02a, 1'b1, 1'b1, 1'b1);
		rsend(9'h011, 1'b0, 1'b1, 1'b1);
		rd(9'h1d5, 1'b0, 1'b0, 1'b0);
		rsend(9'h033, 1'b0, 1'b0, 1'b1);
		rd(9'h02a, 1'b0, 1'b0, 1'b1);
		rd(9'h033, 1'b1, 1'b1, 1'b0);
		chk("rx_complete", 1'b0, rx_complete);
		fmt(3'h7, 1'b0, 1'b0, 1'b1);
		rsend(9'h1c3, 1'b0, 1'b1, 1'b1);
		rsend(9'h0e1, 1'b0, 1'b1, 1'b1);
		rd(9'h1c3, 1'b0, 1'b0, 1'b0);
		rx_enable_bit = 1'b0;
		repeat (3) @(negedge core_clk);
		chk("rx_complete", 1'b0, rx_complete);
		chk("rxd_override", 1'b0, rxd_override);
		summarize();
	end

	initial begin
		#50us;
		chk("watchdog", 12'h000, 12'hfff);
		summarize();
	end
endmodule
